// *** logic/lics_consts.svh ***
// constants for the charge sequencer: thresholds in time, presets, flag positions
// assumes a 20 MHz reference clock and a 1 ms time base tick
`ifndef LICS_CONSTS_SVH
`define LICS_CONSTS_SVH

`define LICS_CLK_HZ 20000000
`define LICS_TICK_MS 1
`define LICS_TICK_CYCLES ((`LICS_CLK_HZ / 1000) * `LICS_TICK_MS)
`define LICS_MS_PER_MIN 60000
`define LICS_FILTER_MS 1
`define LICS_FLASH_PERIOD_MS 1600
`define LICS_FLASH_HALF_MS (`LICS_FLASH_PERIOD_MS / 2)
`define LICS_PRECOND_MIN 32
`define LICS_SAFETY_4H_MIN 240
`define LICS_SAFETY_6H_MIN 360
`define LICS_SAFETY_8H_MIN 480

// safety timer option codes
`define LICS_SAFETY_OFF 2'h0

// current levels driven to the analog front end
`define LICS_CUR_OFF 2'h0
`define LICS_CUR_DETECT 2'h1
`define LICS_CUR_TENTH 2'h2
`define LICS_CUR_FULL 2'h3

// positions in the synchronised flag vector
`define LICS_F_SUPPLY 0
`define LICS_F_PRESENT 1
`define LICS_F_CURRENT_SET_PIN 2
`define LICS_F_SHORT 3
`define LICS_F_SHORT_HI 4
`define LICS_F_PRECOND 5
`define LICS_F_REG 6
`define LICS_F_RECHG 7
`define LICS_F_OVER 8
`define LICS_F_TERM 9
`define LICS_F_HOT 10
`define LICS_F_COOL 11
`define LICS_F_WARM 12
`define LICS_NFLAGS 13

`endif

// *** logic/lics_pkg.sv ***
// types shared by the charge sequencer
// assumes nothing beyond a SystemVerilog compiler
package lics_pkg;

  typedef enum logic [3:0] {
    LICS_SHUTDOWN = 4'h0,
    LICS_STANDBY = 4'h1,
    LICS_SHORT = 4'h2,
    LICS_PRECOND = 4'h3,
    LICS_FAST_CC = 4'h4,
    LICS_CONST_V = 4'h5,
    LICS_COMPLETE = 4'h6,
    LICS_TEMP_FAULT = 4'h7,
    LICS_TIMER_FAULT = 4'h8,
    LICS_PRE_FAULT = 4'h9
  } lics_state_e;

endpackage

// *** logic/lics_sync.sv ***
// two-stage synchroniser for a vector of comparator flags
// assumes each bit is an independent level; no bus coherency is promised
`timescale 1ns/100ps

module lics_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // first stage feeds the second stage only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // lics_sync

// *** logic/lics_charger.sv ***
// charge sequencer for a single lithium cell: state machine, timers, status pin
// assumes comparator flags from the analog front end and one 20 MHz clock
`timescale 1ns/100ps
`include "lics_consts.svh"

module lics_charger #(
  parameter int TICK_CYCLES = `LICS_TICK_CYCLES,
  parameter int MS_PER_MIN = `LICS_MS_PER_MIN,
  parameter int FLASH_HALF_MS = `LICS_FLASH_HALF_MS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic supply_input_ok,
  input wire logic battery_present,
  input wire logic current_set_pin_ok,
  input wire logic battery_voltage_short,
  input wire logic battery_voltage_short_hi,
  input wire logic battery_voltage_precond,
  input wire logic battery_voltage_reg,
  input wire logic battery_voltage_rechg,
  input wire logic battery_voltage_over,
  input wire logic current_below_term,
  input wire logic die_hot,
  input wire logic die_cooled,
  input wire logic die_warm,
  input wire logic [1:0] vreg_select,
  input wire logic [1:0] term_select,
  input wire logic [1:0] safety_select,
  input wire logic precond_en,
  input wire logic precond_timer_en,
  input wire logic recharge_en,
  input wire logic status_type2,
  input wire logic stat_i,
  output logic stat_o,
  output logic stat_oe_n,
  output logic [1:0] current_level,
  output logic cv_mode,
  output logic thermal_derate,
  output logic [1:0] vreg_code,
  output logic [1:0] term_code,
  output logic [3:0] charge_state
);
  default clocking cb_chk @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  generate
    if (TICK_CYCLES < 2 || MS_PER_MIN < 2 || FLASH_HALF_MS < 2) begin : g_bad
      $error("lics_charger: time base parameters too small");
    end
  endgenerate

  function automatic logic [8:0] safety_limit(input logic [1:0] sel);
    case (sel)
      2'h1: safety_limit = 9'(`LICS_SAFETY_4H_MIN);
      2'h2: safety_limit = 9'(`LICS_SAFETY_6H_MIN);
      default: safety_limit = 9'(`LICS_SAFETY_8H_MIN);
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // synchronised flags
  logic [`LICS_NFLAGS-1:0] raw_flags;
  logic [`LICS_NFLAGS-1:0] f;

  assign raw_flags = {die_warm, die_cooled, die_hot, current_below_term, battery_voltage_over,
                      battery_voltage_rechg, battery_voltage_reg, battery_voltage_precond,
                      battery_voltage_short_hi, battery_voltage_short, current_set_pin_ok,
                      battery_present, supply_input_ok};

  lics_sync #(.W(`LICS_NFLAGS)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(raw_flags),
    .sync_out(f)
  );

  wire supply_ok = f[`LICS_F_SUPPLY];
  wire attached = f[`LICS_F_PRESENT] && f[`LICS_F_CURRENT_SET_PIN];

  //////////////////////////////////////////////////////////////////////////////
  // time base: ms tick, minute tick, flash phase
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
  logic [$clog2(MS_PER_MIN)-1:0] ms_cnt;
  logic [$clog2(FLASH_HALF_MS)-1:0] flash_cnt;
  logic flash_phase;
  logic [8:0] min_cnt;
  logic [1:0] term_cnt;
  logic lockout;
  lics_pkg::lics_state_e state;
  lics_pkg::lics_state_e next_state;

  wire ms_tick = (tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  wire min_tick = ms_tick && (ms_cnt == ($clog2(MS_PER_MIN))'(MS_PER_MIN - 1));
  wire flash_end = ms_tick && (flash_cnt == ($clog2(FLASH_HALF_MS))'(FLASH_HALF_MS - 1));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tick_cnt <= '0;
      ms_cnt <= '0;
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end else begin
      tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
      if (ms_tick) ms_cnt <= min_tick ? '0 : ms_cnt + 1'b1;
      if (ms_tick) flash_cnt <= flash_end ? '0 : flash_cnt + 1'b1;
      if (flash_end) flash_phase <= !flash_phase;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // charge timers and termination filter
  wire enter_timed = (next_state != state) &&
                     (next_state == lics_pkg::LICS_FAST_CC || next_state == lics_pkg::LICS_PRECOND);
  wire safety_on = (safety_select != `LICS_SAFETY_OFF);
  wire safety_exp = safety_on && (min_cnt >= safety_limit(safety_select));
  wire pre_exp = precond_timer_en && (min_cnt >= 9'(`LICS_PRECOND_MIN));
  // the ms tick is unaligned to the flag, so one extra tick guarantees a full interval
  wire term_ok = (term_cnt == 2'(`LICS_FILTER_MS + 1));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      min_cnt <= '0;
      term_cnt <= '0;
    end else begin
      if (enter_timed) min_cnt <= '0;
      else if (min_tick && min_cnt != 9'h1ff) min_cnt <= min_cnt + 1'b1;
      if (state != lics_pkg::LICS_CONST_V || !f[`LICS_F_TERM]) term_cnt <= '0;
      else if (ms_tick && !term_ok) term_cnt <= term_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state machine
  wire charging = (state == lics_pkg::LICS_PRECOND) || (state == lics_pkg::LICS_FAST_CC) ||
                  (state == lics_pkg::LICS_CONST_V) || (state == lics_pkg::LICS_SHORT);
  wire qualify = !lockout && attached && f[`LICS_F_RECHG] && !f[`LICS_F_HOT] &&
                 !f[`LICS_F_OVER];
  wire terminate = (state == lics_pkg::LICS_CONST_V) && (term_ok || safety_exp);
  wire is_fault = (state == lics_pkg::LICS_TEMP_FAULT) || (state == lics_pkg::LICS_TIMER_FAULT) ||
                  (state == lics_pkg::LICS_PRE_FAULT);

  always_comb begin
    next_state = state;
    unique case (state)
      lics_pkg::LICS_SHUTDOWN: next_state = lics_pkg::LICS_STANDBY;
      lics_pkg::LICS_STANDBY: begin
        if (qualify) begin
          if (f[`LICS_F_SHORT]) next_state = lics_pkg::LICS_SHORT;
          else if (precond_en && !f[`LICS_F_PRECOND]) next_state = lics_pkg::LICS_PRECOND;
          else next_state = lics_pkg::LICS_FAST_CC;
        end
      end
      lics_pkg::LICS_SHORT:
        if (f[`LICS_F_SHORT_HI]) next_state = lics_pkg::LICS_PRECOND;
      lics_pkg::LICS_PRECOND: begin
        if (pre_exp) next_state = lics_pkg::LICS_PRE_FAULT;
        else if (f[`LICS_F_SHORT]) next_state = lics_pkg::LICS_SHORT;
        else if (f[`LICS_F_PRECOND]) next_state = lics_pkg::LICS_FAST_CC;
      end
      lics_pkg::LICS_FAST_CC: begin
        if (safety_exp) next_state = lics_pkg::LICS_TIMER_FAULT;
        else if (f[`LICS_F_SHORT]) next_state = lics_pkg::LICS_SHORT;
        else if (f[`LICS_F_REG]) next_state = lics_pkg::LICS_CONST_V;
      end
      lics_pkg::LICS_CONST_V:
        if (terminate) next_state = recharge_en ? lics_pkg::LICS_COMPLETE
                                                 : lics_pkg::LICS_STANDBY;
      lics_pkg::LICS_COMPLETE:
        if (recharge_en && f[`LICS_F_RECHG]) next_state = lics_pkg::LICS_STANDBY;
      lics_pkg::LICS_TEMP_FAULT:
        if (f[`LICS_F_COOL]) next_state = lics_pkg::LICS_STANDBY;
      lics_pkg::LICS_TIMER_FAULT, lics_pkg::LICS_PRE_FAULT:
        if (!f[`LICS_F_PRESENT]) next_state = lics_pkg::LICS_STANDBY;
      default: next_state = lics_pkg::LICS_SHUTDOWN;
    endcase
    // overriding conditions, strongest last
    if (charging && f[`LICS_F_OVER]) next_state = lics_pkg::LICS_STANDBY;
    if (charging && f[`LICS_F_HOT]) next_state = lics_pkg::LICS_TEMP_FAULT;
    if ((charging || state == lics_pkg::LICS_COMPLETE || state == lics_pkg::LICS_TEMP_FAULT) &&
        !attached) next_state = lics_pkg::LICS_STANDBY;
    if (!supply_ok) next_state = lics_pkg::LICS_SHUTDOWN;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) state <= lics_pkg::LICS_SHUTDOWN;
    else state <= next_state;
  end

  // removal, current-set pin release or supply loss re-arms a non-recharge part
  always_ff @(posedge ref_clk) begin
    if (!rstn) lockout <= 1'b0;
    else if (terminate && !recharge_en) lockout <= 1'b1;
    else if (!supply_ok || !attached) lockout <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  wire pull_low = charging && state != lics_pkg::LICS_SHORT;
  wire flash_low = is_fault && state != lics_pkg::LICS_SHORT && status_type2 && flash_phase;
  logic [1:0] next_level;

  assign next_level = (state == lics_pkg::LICS_SHORT) ? `LICS_CUR_DETECT :
                      (state == lics_pkg::LICS_PRECOND) ? `LICS_CUR_TENTH :
                      (state == lics_pkg::LICS_FAST_CC || state == lics_pkg::LICS_CONST_V) ?
                      `LICS_CUR_FULL : `LICS_CUR_OFF;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stat_o <= 1'b0;
      stat_oe_n <= 1'b1;
      current_level <= `LICS_CUR_OFF;
      cv_mode <= 1'b0;
      thermal_derate <= 1'b0;
      vreg_code <= 2'h0;
      term_code <= 2'h0;
      charge_state <= 4'h0;
    end else begin
      stat_o <= 1'b0;
      stat_oe_n <= !(pull_low || flash_low);
      current_level <= next_level;
      cv_mode <= (state == lics_pkg::LICS_CONST_V);
      thermal_derate <= f[`LICS_F_WARM];
      vreg_code <= vreg_select;
      term_code <= term_select;
      charge_state <= state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_timer_fault;
    (state == lics_pkg::LICS_FAST_CC && safety_exp && supply_ok && attached &&
     !f[`LICS_F_HOT] && !f[`LICS_F_OVER]) |=> (state == lics_pkg::LICS_TIMER_FAULT);
  endproperty
  a_timer_fault: assert property (p_timer_fault) else $error("no timer fault on expiry");
  property p_fault_hold;
    (state == lics_pkg::LICS_TIMER_FAULT && f[`LICS_F_PRESENT] && supply_ok)
      |=> (state == lics_pkg::LICS_TIMER_FAULT);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("timer fault left early");
  property p_cv_entry;
    $rose(state == lics_pkg::LICS_CONST_V) |-> $past(state) == lics_pkg::LICS_FAST_CC
      && $past(f[`LICS_F_REG]) ##1 cv_mode;
  endproperty
  a_cv_entry: assert property (p_cv_entry) else $error("bad entry to voltage mode");
  property p_term_filter;
    (state == lics_pkg::LICS_CONST_V && !safety_exp && supply_ok && attached && !f[`LICS_F_OVER]
     && !f[`LICS_F_HOT] && (!f[`LICS_F_TERM] || term_cnt == 2'h0))
      |=> (state == lics_pkg::LICS_CONST_V);
  endproperty
  a_term_filter: assert property (p_term_filter) else $error("unfiltered termination");
  property p_hot;
    (charging && f[`LICS_F_HOT] && supply_ok && attached)
      |=> (state == lics_pkg::LICS_TEMP_FAULT) ##1 (stat_oe_n || status_type2);
  endproperty
  a_hot: assert property (p_hot) else $error("hot die did not suspend");
  property p_stat_low;
    (state == lics_pkg::LICS_FAST_CC || state == lics_pkg::LICS_CONST_V)
      |=> !stat_oe_n && current_level == `LICS_CUR_FULL;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status not low while charging");
  property p_type1;
    (is_fault && !status_type2) |=> stat_oe_n;
  endproperty
  a_type1: assert property (p_type1) else $error("type one fault not released");
  property p_timer_restart;
    $rose(state == lics_pkg::LICS_FAST_CC) |-> (min_cnt == 9'h0);
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");
  property p_shutdown;
    !supply_ok |=> (state == lics_pkg::LICS_SHUTDOWN) ##1 (stat_oe_n && current_level == 2'h0);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("supply fault not shut down");

endmodule // lics_charger

// *** verif/lics_stat_host.sv ***
// host input on the open-drain status pin, with the board pull-up
// assumes the charger drives stat_o and stat_oe_n as a split open-drain pin
`timescale 1ns/100ps

module lics_stat_host (
  input wire logic stat_o,
  input wire logic stat_oe_n,
  output logic stat_i,
  output logic stat_level
);
  // a released pin floats up to the pull-up, never to the last driven value
  assign stat_level = stat_oe_n ? 1'b1 : stat_o;
  assign stat_i = stat_level;
endmodule // lics_stat_host

// *** verif/li_ion_charge_sequencer_tb_top.sv ***
// self-checking bench for the charge sequencer with shortened time base
// assumes logic/ on the include path and the host model beside it
`timescale 1ns/100ps
`include "lics_consts.svh"

module li_ion_charge_sequencer_tb_top;
  localparam int TICK = 4;
  localparam int MPM = 4;
  localparam int HALF = 4;
  localparam int T_SAFE = `LICS_SAFETY_4H_MIN * MPM * TICK;
  localparam int T_PRE = `LICS_PRECOND_MIN * MPM * TICK;
  localparam int T6 = `LICS_SAFETY_6H_MIN * MPM * TICK;
  logic ref_clk, rstn, supply_input_ok, battery_present, current_set_pin_ok;
  logic battery_voltage_short, battery_voltage_short_hi, battery_voltage_precond;
  logic battery_voltage_reg, battery_voltage_rechg, battery_voltage_over;
  logic current_below_term, die_hot, die_cooled, die_warm;
  logic [1:0] vreg_select, term_select, safety_select;
  logic precond_en, precond_timer_en, recharge_en, status_type2;
  logic stat_i, stat_o, stat_oe_n, cv_mode, thermal_derate, stat_level, p;
  logic [1:0] current_level, vreg_code, term_code;
  logic [3:0] charge_state;
  int bad_count, cmp_count;

  lics_charger #(.TICK_CYCLES(TICK), .MS_PER_MIN(MPM), .FLASH_HALF_MS(HALF)) i_dut (
    .ref_clk, .rstn, .supply_input_ok, .battery_present, .current_set_pin_ok,
    .battery_voltage_short, .battery_voltage_short_hi, .battery_voltage_precond,
    .battery_voltage_reg, .battery_voltage_rechg, .battery_voltage_over,
    .current_below_term, .die_hot, .die_cooled, .die_warm, .vreg_select,
    .term_select, .safety_select, .precond_en, .precond_timer_en, .recharge_en,
    .status_type2, .stat_i, .stat_o, .stat_oe_n, .current_level, .cv_mode,
    .thermal_derate, .vreg_code, .term_code, .charge_state
  );
  lics_stat_host i_host (.stat_o, .stat_oe_n, .stat_i, .stat_level);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic pin_exp(input lics_pkg::lics_state_e s);
    return !(s inside {lics_pkg::LICS_PRECOND, lics_pkg::LICS_FAST_CC, lics_pkg::LICS_CONST_V});
  endfunction

  function automatic logic [1:0] cur_exp(input lics_pkg::lics_state_e s);
    case (s)
      lics_pkg::LICS_SHORT: return `LICS_CUR_DETECT;
      lics_pkg::LICS_PRECOND: return `LICS_CUR_TENTH;
      lics_pkg::LICS_FAST_CC, lics_pkg::LICS_CONST_V: return `LICS_CUR_FULL;
      default: return `LICS_CUR_OFF;
    endcase
  endfunction

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk_state(input logic [3:0] exp);
    cmp_count++;
    if (charge_state !== exp) begin
      bad_count++;
      $display("BAD t=%0t state got %h exp %h", $time, charge_state, exp);
    end
  endtask

  task automatic chk_code(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t code got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t bit got %h exp %h", $time, got, exp);
    end
  endtask

  // state, pin level and commanded current together
  task automatic expect_st(input lics_pkg::lics_state_e s);
    chk_state(s);
    chk_bit(stat_level, pin_exp(s));
    chk_code(current_level, cur_exp(s));
    chk_bit(cv_mode, s == lics_pkg::LICS_CONST_V);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // the timer faults dominate the run; this leaves ample margin beyond them
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    rstn = 1'b0;
    {supply_input_ok, battery_present, current_set_pin_ok, battery_voltage_short,
     battery_voltage_short_hi, battery_voltage_precond, battery_voltage_reg,
     battery_voltage_rechg, battery_voltage_over, current_below_term, die_hot,
     die_warm, vreg_select, term_select, safety_select, precond_en,
     precond_timer_en, recharge_en, status_type2} = '0;
    die_cooled = 1'b1;
    void'($urandom(43));
    step(3);
    expect_st(lics_pkg::LICS_SHUTDOWN);
    step(2);
    rstn = 1'b1;
    {supply_input_ok, battery_present, current_set_pin_ok, battery_voltage_rechg} = 4'hf;
    precond_en = 1'b1;
    safety_select = 2'h1;
    step(14);
    expect_st(lics_pkg::LICS_PRECOND);
    battery_voltage_precond = 1'b1;
    step(8);
    expect_st(lics_pkg::LICS_FAST_CC);
    for (int i = 0; i < 4; i++) begin
      vreg_select = 2'(i);
      term_select = ~2'(i);
      die_warm = 1'($urandom);
      step(6);
      chk_code(vreg_code, 2'(i));
      chk_code(term_code, ~2'(i));
      chk_bit(thermal_derate, die_warm);
    end
    battery_voltage_reg = 1'b1;
    battery_voltage_rechg = 1'b0;
    step(8);
    expect_st(lics_pkg::LICS_CONST_V);
    chk_bit(cv_mode, 1'b1);
    // glitches shorter than one tick must never terminate
    repeat (4) begin
      current_below_term = 1'b1;
      step(1 + $urandom % 3);
      current_below_term = 1'b0;
      step(6);
      chk_state(lics_pkg::LICS_CONST_V);
    end
    recharge_en = 1'b1;
    current_below_term = 1'b1;
    step(20);
    expect_st(lics_pkg::LICS_COMPLETE);
    current_below_term = 1'b0;
    battery_voltage_reg = 1'b0;
    step(10);
    chk_state(lics_pkg::LICS_COMPLETE);
    battery_voltage_rechg = 1'b1;
    step(14);
    expect_st(lics_pkg::LICS_FAST_CC);
    battery_voltage_over = 1'b1;
    step(8);
    expect_st(lics_pkg::LICS_STANDBY);
    battery_voltage_over = 1'b0;
    step(14);
    expect_st(lics_pkg::LICS_FAST_CC);
    status_type2 = 1'b1;
    die_hot = 1'b1;
    die_cooled = 1'b0;
    step(8);
    chk_state(lics_pkg::LICS_TEMP_FAULT);
    chk_code(current_level, `LICS_CUR_OFF);
    // lock onto a toggle, then expect the next one one half period later
    p = stat_level;
    for (int k = 0; k < 3 * HALF * TICK && stat_level === p; k++) step(1);
    p = stat_level;
    step(HALF * TICK / 2);
    chk_bit(stat_level, p);
    step(HALF * TICK + 4 - HALF * TICK / 2);
    chk_bit(stat_level, ~p);
    status_type2 = 1'b0;
    step(6);
    chk_bit(stat_level, 1'b1);
    step(HALF * TICK);
    chk_bit(stat_level, 1'b1);
    die_hot = 1'b0;
    die_cooled = 1'b1;
    step(16);
    expect_st(lics_pkg::LICS_FAST_CC);
    step(T_SAFE - 260);
    chk_state(lics_pkg::LICS_FAST_CC);
    step(300);
    expect_st(lics_pkg::LICS_TIMER_FAULT);
    step(40);
    chk_state(lics_pkg::LICS_TIMER_FAULT);
    battery_present = 1'b0;
    step(8);
    expect_st(lics_pkg::LICS_STANDBY);
    battery_voltage_precond = 1'b0;
    precond_timer_en = 1'b1;
    battery_present = 1'b1;
    step(12);
    expect_st(lics_pkg::LICS_PRECOND);
    step(T_PRE - 60);
    chk_state(lics_pkg::LICS_PRECOND);
    step(100);
    expect_st(lics_pkg::LICS_PRE_FAULT);
    supply_input_ok = 1'b0;
    step(8);
    expect_st(lics_pkg::LICS_SHUTDOWN);
    supply_input_ok = 1'b1;
    battery_voltage_short = 1'b1;
    step(14);
    expect_st(lics_pkg::LICS_SHORT);
    battery_voltage_short = 1'b0;
    step(10);
    chk_state(lics_pkg::LICS_SHORT);
    battery_voltage_short_hi = 1'b1;
    step(8);
    expect_st(lics_pkg::LICS_PRECOND);
    battery_voltage_precond = 1'b1;
    battery_voltage_reg = 1'b1;
    battery_voltage_rechg = 1'b0;
    recharge_en = 1'b0;
    step(16);
    chk_state(lics_pkg::LICS_CONST_V);
    current_below_term = 1'b1;
    step(24);
    expect_st(lics_pkg::LICS_STANDBY);
    {battery_voltage_rechg, current_below_term, battery_voltage_reg} = 3'h4;
    step(14);
    chk_state(lics_pkg::LICS_STANDBY);
    current_set_pin_ok = 1'b0;
    step(8);
    current_set_pin_ok = 1'b1;
    step(16);
    expect_st(lics_pkg::LICS_FAST_CC);
    // disabled timer outlives the shortest period, the longest setting then holds, then the middle one expires
    safety_select = 2'h0;
    step(T_SAFE + 200);
    chk_state(lics_pkg::LICS_FAST_CC);
    safety_select = 2'h3;
    step(T6 - T_SAFE - 460);
    chk_state(lics_pkg::LICS_FAST_CC);
    safety_select = 2'h2;
    step(200);
    chk_state(lics_pkg::LICS_FAST_CC);
    step(100);
    expect_st(lics_pkg::LICS_TIMER_FAULT);
    // without preconditioning a low cell goes straight to full current
    battery_present = 1'b0;
    precond_en = 1'b0;
    battery_voltage_precond = 1'b0;
    step(8);
    expect_st(lics_pkg::LICS_STANDBY);
    battery_present = 1'b1;
    step(12);
    expect_st(lics_pkg::LICS_FAST_CC);
    final_report();
  end
endmodule // li_ion_charge_sequencer_tb_top
